/* design/cpu_regfile_temp_guard_pkg.sv */
/*
  Shared constants, enumerations and carrier structs for the CPU register
  support block: working registers, byte staging latch and change guard.
  Assumes a single CPU clock and one 8-bit data path.
*/
`default_nettype none

package cpu_regfile_temp_guard_pkg;

  // working register file shape
  localparam int unsigned RF_COUNT   = 32;
  localparam int unsigned RF_WIDTH   = 8;
  localparam logic [4:0]  RF_UPPER   = 5'h10;  // first register reachable with immediates
  localparam logic [4:0]  PTR_X_LOW  = 5'h1A;  // low byte of the first pointer pair
  localparam logic [4:0]  PTR_Y_LOW  = 5'h1C;
  localparam logic [4:0]  PTR_Z_LOW  = 5'h1E;

  // cpu-space register map
  localparam logic [5:0]  CHANGE_GUARD_OFS = 6'h04;
  localparam logic [5:0]  STACK_PTR_OFS    = 6'h0D;  // held outside this block
  localparam logic [5:0]  CPU_FLAGS_OFS    = 6'h0F;  // held outside this block

  // change guard signatures, status bits and window length
  localparam logic [7:0]  SELF_PROGRAM_UNLOCK = 8'h9D;
  localparam logic [7:0]  PROTECTED_IO_UNLOCK = 8'hD8;
  localparam int unsigned GUARD_IO_BIT        = 0;
  localparam int unsigned GUARD_SPM_BIT       = 1;
  localparam logic [2:0]  GUARD_INSNS         = 3'h4;
  localparam logic [7:0]  GUARD_RESET         = 8'h00;

  typedef enum logic [1:0] {
    PTR_X = 2'b00,
    PTR_Y = 2'b01,
    PTR_Z = 2'b10
  } ptr_sel_e;

  typedef enum logic [1:0] {
    PTR_DISP    = 2'b00,
    PTR_POSTINC = 2'b01,
    PTR_PREDEC  = 2'b10
  } ptr_mode_e;

  // working register write request
  typedef struct packed {
    logic       en;
    logic       imm;   // immediate-operand form
    logic [4:0] addr;
    logic [7:0] data;
  } rf_wr_s;

  // indirect pointer request
  typedef struct packed {
    logic      en;
    ptr_sel_e  sel;
    ptr_mode_e mode;
    logic [5:0] disp;
  } ptr_req_s;

  // byte access to a 16-bit peripheral register
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic       hi;    // 1: high byte, 0: low byte
    logic [7:0] data;
  } io16_s;

  // whole state of the block
  typedef struct packed {
    logic [31:0][7:0] rf;
    logic [7:0]       rd_a;
    logic [7:0]       rd_b;
    logic [15:0]      ptr_addr;
    logic [7:0]       temp;
    logic [7:0]       io_rdata;
    logic             per_wr;
    logic [15:0]      per_wdata;
    logic [7:0]       cpu_rdata;
    logic             io_open;
    logic             spm_open;
    logic [2:0]       cnt;
    logic             prot_ok;
    logic             spm_ok;
  } state_s;

endpackage

`default_nettype wire

/* design/cpu_regfile_temp_guard.sv */
/*
  CPU register support: 32 working registers with three pointer pairs,
  byte staging latch for 16-bit peripheral registers, and the change
  guard with its timed unlock windows and interrupt hold.
  Assumes all inputs synchronous to clock_i and one-cycle strobes.
*/
// Behaviour
// (RL1) thirty-two working registers of eight bits each
// (RL2) working registers have their own address space, not data memory
// (RL3) register reads and writes complete within one clock cycle
// (RL4) immediate-form writes reach only registers sixteen to thirty-one
// (RL5) registers twenty-six to thirty-one form three 16-bit pointers
// (RL6) lower register of a pair is the low byte
// (RL7) the third pointer also addresses program memory
// (RL8) pointers support displacement, post-increment and pre-decrement
// (RL9) 16-bit peripheral registers go through one shared byte latch
// (RL10) low-byte write loads only the latch
// (RL11) high-byte write writes high byte and latch as low byte together
// (RL12) software writes the low byte before the high byte
// (RL13) low-byte read returns low byte and latches the high byte
// (RL14) high-byte read returns the latch; low byte is read first
// (RL15) software guards 16-bit accesses against service routines
// (RL16) protected writes and self-programming refused without an unlock
// (RL17) protected write accepted only within four instructions of unlock
// (RL18) software sets the enable bit in the protected data write
// (RL19) io window closes on memory writes, nvm accesses or sleep
// (RL20) self-programming window: four instructions, closed by nvm access or sleep
// (RL21) no interrupt serviced while a window is open
// (RL22) pending interrupts serviced once the window ends
// (RL23) signatures open the windows; bits zero and one show them
// (RL24) upper six guard bits read zero
// (RL25) instruction counter closes each window on expiry or cancel
`default_nettype none

module cpu_regfile_temp_guard
  import cpu_regfile_temp_guard_pkg::*;
(
  input  wire logic        clock_i,
  input  wire logic        rst_n_i,
  // working register ports
  input  wire logic [4:0]  rf_ra_i,
  input  wire logic [4:0]  rf_rb_i,
  input  wire rf_wr_s      rf_wr_i,
  output var  logic [7:0]  rf_a_o,
  output var  logic [7:0]  rf_b_o,
  // pointer ports
  input  wire ptr_req_s    ptr_req_i,
  output var  logic [15:0] ptr_addr_o,
  output var  logic [15:0] prog_addr_o,
  // 16-bit peripheral access
  input  wire io16_s       io16_i,
  input  wire logic [15:0] per_val_i,
  output var  logic [7:0]  io16_rdata_o,
  output var  logic        per_wr_o,
  output var  logic [15:0] per_wdata_o,
  // cpu-space register access
  input  wire logic [5:0]  cpu_addr_i,
  input  wire logic        cpu_wr_i,
  input  wire logic        cpu_rd_i,
  input  wire logic [7:0]  cpu_wdata_i,
  output var  logic [7:0]  cpu_rdata_o,
  // guard events
  input  wire logic        insn_done_i,
  input  wire logic        io_dm_wr_i,
  input  wire logic        nvm_acc_i,
  input  wire logic        sleep_i,
  input  wire logic        prot_wr_i,
  input  wire logic        spm_store_i,
  output var  logic        prot_ok_o,
  output var  logic        spm_ok_o,
  output var  logic        irq_hold_o
);

  ////////////////////////////////////////////////////////////////////////
  // helpers

  // 16-bit value of a pointer pair, low register first
  function automatic logic [15:0] ptr_val(input logic [31:0][7:0] rf,
                                          input ptr_sel_e sel);
    logic [4:0] lo;
    lo = PTR_X_LOW;
    unique case (sel)
      PTR_X:   lo = PTR_X_LOW;
      PTR_Y:   lo = PTR_Y_LOW;
      PTR_Z:   lo = PTR_Z_LOW;
      default: lo = PTR_X_LOW;
    endcase
    ptr_val = {rf[lo + 5'h01], rf[lo]};  // RL6
  endfunction

  // register index of a pointer pair low byte
  function automatic logic [4:0] ptr_low(input ptr_sel_e sel);
    ptr_low = PTR_X_LOW;
    unique case (sel)
      PTR_X:   ptr_low = PTR_X_LOW;
      PTR_Y:   ptr_low = PTR_Y_LOW;
      PTR_Z:   ptr_low = PTR_Z_LOW;
      default: ptr_low = PTR_X_LOW;
    endcase
  endfunction

  state_s s_q;
  state_s s_d;

  logic        cg_wr;
  logic        cg_rd;
  logic [15:0] ptr_cur;
  logic [4:0]  ptr_lo;
  logic [4:0]  wr_idx;

  ////////////////////////////////////////////////////////////////////////
  // next-state logic

  // guard register decode; other cpu-space offsets are not held here
  assign cg_wr   = cpu_wr_i && (cpu_addr_i == CHANGE_GUARD_OFS);
  assign cg_rd   = cpu_rd_i && (cpu_addr_i == CHANGE_GUARD_OFS);
  assign ptr_cur = ptr_val(s_q.rf, ptr_req_i.sel);
  assign ptr_lo  = ptr_low(ptr_req_i.sel);
  // immediate forms can only name the upper half
  assign wr_idx  = rf_wr_i.imm ? (rf_wr_i.addr | RF_UPPER) : rf_wr_i.addr;  // RL4

  always_comb begin
    logic [15:0] upd;
    upd = ptr_cur;
    s_d = s_q;
    s_d.per_wr  = 1'b0;
    s_d.prot_ok = 1'b0;
    s_d.spm_ok  = 1'b0;

    // working registers: private array, never on the data memory path
    s_d.rd_a = s_q.rf[rf_ra_i];  // RL1 RL2 RL3
    s_d.rd_b = s_q.rf[rf_rb_i];  // RL3
    if (rf_wr_i.en) begin
      s_d.rf[wr_idx] = rf_wr_i.data;  // RL3
    end

    // pointer addressing; the pointer update wins over a plain write
    unique case (ptr_req_i.mode)
      PTR_POSTINC: upd = ptr_cur + 16'h0001;
      PTR_PREDEC:  upd = ptr_cur - 16'h0001;
      default:     upd = ptr_cur;
    endcase
    if (ptr_req_i.en) begin
      unique case (ptr_req_i.mode)
        PTR_DISP:    s_d.ptr_addr = ptr_cur + {10'h000, ptr_req_i.disp};  // RL8
        PTR_POSTINC: s_d.ptr_addr = ptr_cur;  // RL8
        PTR_PREDEC:  s_d.ptr_addr = upd;  // RL8
        default:     s_d.ptr_addr = ptr_cur;
      endcase
      if (ptr_req_i.mode != PTR_DISP) begin
        s_d.rf[ptr_lo]         = upd[7:0];  // RL5 RL6
        s_d.rf[ptr_lo + 5'h01] = upd[15:8];  // RL6
      end
    end

    // 16-bit peripheral access through the staging latch
    if (io16_i.wr && !io16_i.hi) begin
      s_d.temp = io16_i.data;  // RL9 RL10
    end else if (io16_i.wr && io16_i.hi) begin
      s_d.per_wr    = 1'b1;  // RL11
      s_d.per_wdata = {io16_i.data, s_q.temp};  // RL11
    end else if (io16_i.rd && !io16_i.hi) begin
      s_d.io_rdata = per_val_i[7:0];  // RL13
      s_d.temp     = per_val_i[15:8];  // RL13
    end else if (io16_i.rd && io16_i.hi) begin
      s_d.io_rdata = s_q.temp;  // RL14
    end

    // guard register read: only the two window bits exist
    if (cg_rd) begin
      s_d.cpu_rdata = 8'h00;  // RL24
      s_d.cpu_rdata[GUARD_IO_BIT]  = s_q.io_open;  // RL23
      s_d.cpu_rdata[GUARD_SPM_BIT] = s_q.spm_open;  // RL23
    end else if (cpu_rd_i) begin
      s_d.cpu_rdata = 8'h00;  // unmapped here
    end

    // acceptance uses the window as it stood before this cycle
    s_d.prot_ok = prot_wr_i && s_q.io_open;  // RL16 RL17
    s_d.spm_ok  = spm_store_i && s_q.spm_open;  // RL16 RL20

    // count executed instructions while a window is open
    if ((s_q.io_open || s_q.spm_open) && insn_done_i) begin
      s_d.cnt = s_q.cnt - 3'h1;  // RL25
      if (s_q.cnt == 3'h1) begin
        s_d.io_open  = 1'b0;  // RL17
        s_d.spm_open = 1'b0;  // RL20
      end
    end

    // cancelling events; the guarded access itself also ends the window
    if (io_dm_wr_i || nvm_acc_i || sleep_i || prot_wr_i) begin
      s_d.io_open = 1'b0;  // RL19 RL25
    end
    if (nvm_acc_i || sleep_i || spm_store_i) begin
      s_d.spm_open = 1'b0;  // RL20 RL25
    end

    // a fresh signature wins over any close in the same cycle
    if (cg_wr && cpu_wdata_i == PROTECTED_IO_UNLOCK) begin
      s_d.io_open  = 1'b1;  // RL23
      s_d.spm_open = 1'b0;
      s_d.cnt      = GUARD_INSNS;
    end else if (cg_wr && cpu_wdata_i == SELF_PROGRAM_UNLOCK) begin
      s_d.spm_open = 1'b1;  // RL23
      s_d.io_open  = 1'b0;
      s_d.cnt      = GUARD_INSNS;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // state register

  // async reset to constants only; guard and latch come up closed and clear
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // outputs from state flops; irq_hold_o is the OR of the two window flops
  assign rf_a_o       = s_q.rd_a;
  assign rf_b_o       = s_q.rd_b;
  assign ptr_addr_o   = s_q.ptr_addr;
  assign prog_addr_o  = {s_q.rf[PTR_Z_LOW + 5'h01], s_q.rf[PTR_Z_LOW]};  // RL7
  assign io16_rdata_o = s_q.io_rdata;
  assign per_wr_o     = s_q.per_wr;
  assign per_wdata_o  = s_q.per_wdata;
  assign cpu_rdata_o  = s_q.cpu_rdata;
  assign prot_ok_o    = s_q.prot_ok;
  assign spm_ok_o     = s_q.spm_ok;
  // interrupt controller holds service off while high, pending kept
  assign irq_hold_o   = s_q.io_open || s_q.spm_open;  // RL21 RL22

  ////////////////////////////////////////////////////////////////////////
  // assertions

  imm_upper_a: assert property (@(posedge clock_i) disable iff (!rst_n_i) // RL4
    rf_wr_i.en && rf_wr_i.imm && !ptr_req_i.en |=>
      s_q.rf[{1'b1, $past(rf_wr_i.addr[3:0])}] == $past(rf_wr_i.data))
    else $error("immediate write missed upper register");

  rf_write_a: assert property (@(posedge clock_i) disable iff (!rst_n_i) // RL3
    rf_wr_i.en && !rf_wr_i.imm && !ptr_req_i.en ##1 (rf_ra_i == $past(rf_wr_i.addr))
      |=> rf_a_o == $past(rf_wr_i.data, 2))
    else $error("register write not read back");

  ptr_post_a: assert property (@(posedge clock_i) disable iff (!rst_n_i) // RL8
    ptr_req_i.en && ptr_req_i.mode == PTR_POSTINC && !rf_wr_i.en |=>
      ptr_addr_o == $past(ptr_cur) &&
      ptr_val(s_q.rf, $past(ptr_req_i.sel)) == $past(ptr_cur) + 16'h0001)
    else $error("post-increment wrong");

  low_wr_a: assert property (@(posedge clock_i) disable iff (!rst_n_i) // RL10
    io16_i.wr && !io16_i.hi ##1 (io16_i.wr && io16_i.hi) |=>
      per_wr_o && per_wdata_o[7:0] == $past(io16_i.data, 2))
    else $error("low byte not staged");

  high_wr_a: assert property (@(posedge clock_i) disable iff (!rst_n_i) // RL11
    io16_i.wr && io16_i.hi |=> per_wr_o && per_wdata_o[15:8] == $past(io16_i.data))
    else $error("high byte write wrong");

  pair_rd_a: assert property (@(posedge clock_i) disable iff (!rst_n_i) // RL14
    io16_i.rd && !io16_i.hi && !io16_i.wr ##1 (io16_i.rd && io16_i.hi && !io16_i.wr) |=>
      io16_rdata_o == $past(per_val_i[15:8], 2))
    else $error("high byte read not from latch");

  refuse_a: assert property (@(posedge clock_i) disable iff (!rst_n_i) // RL16
    prot_wr_i && !s_q.io_open |=> !prot_ok_o)
    else $error("protected write accepted while locked");

  window_len_a: assert property (@(posedge clock_i) disable iff (!rst_n_i) // RL17
    cg_wr && cpu_wdata_i == PROTECTED_IO_UNLOCK ##1
      (insn_done_i && !cg_wr && !io_dm_wr_i && !nvm_acc_i && !sleep_i && !prot_wr_i)[*4]
      |=> !irq_hold_o)
    else $error("io window outlived four instructions");

  cancel_a: assert property (@(posedge clock_i) disable iff (!rst_n_i) // RL19
    s_q.io_open && (io_dm_wr_i || sleep_i) && !cg_wr |=> !s_q.io_open)
    else $error("io window not closed");

  spm_cancel_a: assert property (@(posedge clock_i) disable iff (!rst_n_i) // RL20
    s_q.spm_open && nvm_acc_i && !cg_wr |=> !s_q.spm_open)
    else $error("spm window not closed");

  hold_a: assert property (@(posedge clock_i) disable iff (!rst_n_i) // RL21
    cg_wr && cpu_wdata_i == SELF_PROGRAM_UNLOCK |=> irq_hold_o && s_q.cnt == GUARD_INSNS)
    else $error("interrupts not held after unlock");

  guard_rd_a: assert property (@(posedge clock_i) disable iff (!rst_n_i) // RL24
    cg_rd |=> cpu_rdata_o[7:2] == 6'h00 && cpu_rdata_o[0] == $past(s_q.io_open))
    else $error("guard read wrong");

  rf_port_b_a: assert property (@(posedge clock_i) disable iff (!rst_n_i) // RL1
    rf_wr_i.en && !rf_wr_i.imm && !ptr_req_i.en ##1 (rf_rb_i == $past(rf_wr_i.addr))
      |=> rf_b_o == $past(rf_wr_i.data, 2))
    else $error("second read port missed write");

  ptr_pre_a: assert property (@(posedge clock_i) disable iff (!rst_n_i) // RL8
    ptr_req_i.en && ptr_req_i.mode == PTR_PREDEC |=> ptr_addr_o == $past(ptr_cur) - 16'h0001)
    else $error("pre-decrement wrong");

  ptr_disp_a: assert property (@(posedge clock_i) disable iff (!rst_n_i) // RL8
    ptr_req_i.en && ptr_req_i.mode == PTR_DISP |=>
      ptr_addr_o == $past(ptr_cur) + {10'h000, $past(ptr_req_i.disp)})
    else $error("displacement wrong");

  prog_ptr_a: assert property (@(posedge clock_i) disable iff (!rst_n_i) // RL7
    ptr_req_i.en && ptr_req_i.sel == PTR_Z && ptr_req_i.mode == PTR_DISP &&
      ptr_req_i.disp == 6'h00 && !rf_wr_i.en |=> prog_addr_o == ptr_addr_o)
    else $error("program address differs from third pointer");

  low_rd_a: assert property (@(posedge clock_i) disable iff (!rst_n_i) // RL13
    io16_i.rd && !io16_i.hi && !io16_i.wr |=> io16_rdata_o == $past(per_val_i[7:0]))
    else $error("low byte read wrong");

  low_only_a: assert property (@(posedge clock_i) disable iff (!rst_n_i) // RL10
    io16_i.wr && !io16_i.hi |=> !per_wr_o)
    else $error("low byte write reached register");

  spm_refuse_a: assert property (@(posedge clock_i) disable iff (!rst_n_i) // RL16
    spm_store_i && !s_q.spm_open |=> !spm_ok_o)
    else $error("store accepted while locked");

  io_accept_a: assert property (@(posedge clock_i) disable iff (!rst_n_i) // RL17
    prot_wr_i && s_q.io_open && !cg_wr |=> prot_ok_o && !irq_hold_o)
    else $error("open window write not accepted");

  hold_release_a: assert property (@(posedge clock_i) disable iff (!rst_n_i) // RL22
    irq_hold_o && sleep_i && !cg_wr |=> !irq_hold_o)
    else $error("interrupt hold not released");

  io_unlock_c: cover property (@(posedge clock_i) disable iff (!rst_n_i)
    cg_wr && cpu_wdata_i == PROTECTED_IO_UNLOCK ##[1:4] prot_wr_i ##1 prot_ok_o);
  spm_unlock_c: cover property (@(posedge clock_i) disable iff (!rst_n_i)
    cg_wr && cpu_wdata_i == SELF_PROGRAM_UNLOCK ##[1:4] spm_store_i ##1 spm_ok_o);
  pair_wr_c: cover property (@(posedge clock_i) disable iff (!rst_n_i)
    io16_i.wr && !io16_i.hi ##1 io16_i.wr && io16_i.hi);
  pre_dec_c: cover property (@(posedge clock_i) disable iff (!rst_n_i)
    ptr_req_i.en && ptr_req_i.mode == PTR_PREDEC);
  pair_rd_c: cover property (@(posedge clock_i) disable iff (!rst_n_i)
    io16_i.rd && !io16_i.hi ##[1:4] io16_i.rd && io16_i.hi);

endmodule

`default_nettype wire

/* test/periph16_model.sv */
/*
  Partner model: one 16-bit peripheral register that counts while run_i is high.
  Assumes one-cycle write pulses from the block on the shared CPU clock.
*/
`default_nettype none

module periph16_model (
  input  wire logic        clock_i,
  input  wire logic        rst_n_i,
  input  wire logic        run_i,
  input  wire logic        wr_i,
  input  wire logic [15:0] wdata_i,
  output var  logic [15:0] val_o
);
  timeunit 1ns;
  timeprecision 1ps;

  // counting makes a torn 16-bit read show up as a wrong high byte
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) val_o <= 16'h0000;
    else if (wr_i) val_o <= wdata_i;
    else if (run_i) val_o <= val_o + 16'h0001;
  end
endmodule

`default_nettype wire

/* test/tb_cpu_regfile_temp_guard.sv */
/*
  Self-checking bench: working registers, pointers, byte latch, change guard.
  Assumes the block samples every input on the rising edge of clock_i.
*/
`default_nettype none

module tb_cpu_regfile_temp_guard
  import cpu_regfile_temp_guard_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic        clock_i = 1'b0;
  logic        rst_n_i = 1'b0;
  logic [4:0]  rf_ra_i = 5'h00;
  logic [4:0]  rf_rb_i = 5'h00;
  rf_wr_s      rf_wr_i = '0;
  ptr_req_s    ptr_req_i = '0;
  io16_s       io16_i = '0;
  logic [5:0]  cpu_addr_i = 6'h00;
  logic        cpu_wr_i = 1'b0;
  logic        cpu_rd_i = 1'b0;
  logic [7:0]  cpu_wdata_i = 8'h00;
  logic [5:0]  evt = 6'h00;  // spm store, prot write, sleep, nvm, io/dm write, insn
  logic        run = 1'b0;
  logic [7:0]  rf_a_o, rf_b_o, io16_rdata_o, cpu_rdata_o;
  logic [15:0] ptr_addr_o, prog_addr_o, per_val_i, per_wdata_o;
  logic        per_wr_o, prot_ok_o, spm_ok_o, irq_hold_o;
  int          err_total = 0;
  int          samples_checked = 0;
  int          cycles = 0;

  cpu_regfile_temp_guard dut (.clock_i(clock_i), .rst_n_i(rst_n_i), .rf_ra_i(rf_ra_i),
    .rf_rb_i(rf_rb_i), .rf_wr_i(rf_wr_i), .rf_a_o(rf_a_o), .rf_b_o(rf_b_o),
    .ptr_req_i(ptr_req_i), .ptr_addr_o(ptr_addr_o), .prog_addr_o(prog_addr_o),
    .io16_i(io16_i), .per_val_i(per_val_i), .io16_rdata_o(io16_rdata_o),
    .per_wr_o(per_wr_o), .per_wdata_o(per_wdata_o), .cpu_addr_i(cpu_addr_i),
    .cpu_wr_i(cpu_wr_i), .cpu_rd_i(cpu_rd_i), .cpu_wdata_i(cpu_wdata_i),
    .cpu_rdata_o(cpu_rdata_o), .insn_done_i(evt[0]), .io_dm_wr_i(evt[1]),
    .nvm_acc_i(evt[2]), .sleep_i(evt[3]), .prot_wr_i(evt[4]), .spm_store_i(evt[5]),
    .prot_ok_o(prot_ok_o), .spm_ok_o(spm_ok_o), .irq_hold_o(irq_hold_o));

  periph16_model peri (.clock_i(clock_i), .rst_n_i(rst_n_i), .run_i(run),
    .wr_i(per_wr_o), .wdata_i(per_wdata_o), .val_o(per_val_i));

  ////////////////////////////////////////
  // clock, hang guard, reporting
  always #2.5 clock_i = ~clock_i;

  always @(posedge clock_i) begin
    cycles++;
    if (cycles == 3000) begin
      err_total++;
      conclude();
    end
  end

  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic conclude;
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  ////////////////////////////////////////
  // one-cycle request helpers; outputs are looked at 1 ns after the taking edge
  task automatic rf_write(input logic imm, input logic [4:0] a, input logic [7:0] d);
    @(posedge clock_i);
    rf_wr_i <= '{1'b1, imm, a, d};
    @(posedge clock_i);
    rf_wr_i <= '0;
  endtask

  task automatic rf_read(input logic [4:0] a, b, input logic [7:0] ea, eb);
    @(posedge clock_i);
    rf_ra_i <= a;
    rf_rb_i <= b;
    @(posedge clock_i);
    #1;
    check("rf_a_o", ea, rf_a_o);
    check("rf_b_o", eb, rf_b_o);
  endtask

  task automatic ptr(input ptr_sel_e s, input ptr_mode_e m, input logic [5:0] dp,
                     input logic [15:0] ea);
    @(posedge clock_i);
    ptr_req_i <= '{1'b1, s, m, dp};
    @(posedge clock_i);
    ptr_req_i <= '0;
    #1;
    check("ptr_addr_o", ea, ptr_addr_o);
  endtask

  task automatic io16(input logic w, r, h, input logic [7:0] d);
    @(posedge clock_i);
    io16_i <= '{w, r, h, d};
    @(posedge clock_i);
    io16_i <= '0;
    #1;
  endtask

  task automatic cpu(input logic w, input logic [5:0] a, input logic [7:0] d);
    @(posedge clock_i);
    cpu_wr_i <= w;
    cpu_rd_i <= !w;
    cpu_addr_i <= a;
    cpu_wdata_i <= d;
    @(posedge clock_i);
    cpu_wr_i <= 1'b0;
    cpu_rd_i <= 1'b0;
    #1;
  endtask

  // k picks one guard event (0 none); ins adds an executed instruction
  task automatic ev(input int k, input logic ins);
    @(posedge clock_i);
    evt <= {k == 5, k == 4, k == 3, k == 2, k == 1, ins};
    @(posedge clock_i);
    evt <= '0;
    #1;
  endtask

  ////////////////////////////////////////
  // scenarios
  task automatic t_reset;
    @(posedge clock_i);
    #1;
    check("irq_hold_o", 16'h0000, irq_hold_o);
    cpu(1'b0, CHANGE_GUARD_OFS, 8'h00);
    check("guard read", 16'h0000, cpu_rdata_o);
    cpu(1'b0, STACK_PTR_OFS, 8'h00);
    check("unmapped read", 16'h0000, cpu_rdata_o);
  endtask

  task automatic t_regs;
    rf_write(1'b0, 5'h05, 8'hAA);
    rf_write(1'b1, 5'h05, 8'h5A);
    rf_read(5'h05, 5'h15, 8'hAA, 8'h5A);
  endtask

  task automatic t_ptr;
    logic [7:0] init [6] = '{8'hFF, 8'h00, 8'h00, 8'h01, 8'h34, 8'h12};
    for (int i = 0; i < 6; i++) rf_write(1'b0, PTR_X_LOW + 5'(i), init[i]);
    ptr(PTR_X, PTR_POSTINC, 6'h00, 16'h00FF);
    rf_read(5'h1A, 5'h1B, 8'h00, 8'h01);
    ptr(PTR_Y, PTR_PREDEC, 6'h00, 16'h00FF);
    rf_read(5'h1C, 5'h1D, 8'hFF, 8'h00);
    ptr(PTR_Z, PTR_DISP, 6'h3F, 16'h1273);
    check("prog_addr_o", 16'h1234, prog_addr_o);
    rf_read(5'h1E, 5'h1F, 8'h34, 8'h12);
  endtask

  task automatic t_io16;
    // no service routine runs here, so the latch is never shared mid-pair
    io16(1'b1, 1'b0, 1'b0, 8'h34);
    check("per_wr_o lo", 16'h0000, per_wr_o);
    io16(1'b1, 1'b0, 1'b1, 8'h12);
    check("per_wr_o hi", 16'h0001, per_wr_o);
    check("per_wdata_o", 16'h1234, per_wdata_o);
    io16(1'b1, 1'b0, 1'b0, 8'hFF);
    check("per_val_i", 16'h1234, per_val_i);
    io16(1'b1, 1'b0, 1'b1, 8'h12);
    io16(1'b0, 1'b1, 1'b0, 8'h00);
    check("read lo", 16'h00FF, io16_rdata_o);
    @(posedge clock_i);
    run <= 1'b1;  // carry into the high byte before it is read
    io16(1'b0, 1'b1, 1'b1, 8'h00);
    check("read hi", 16'h0012, io16_rdata_o);
    run <= 1'b0;
  endtask

  task automatic t_guard_io;
    ev(4, 1'b0);
    check("locked write", 16'h0000, prot_ok_o);
    cpu(1'b1, CHANGE_GUARD_OFS, 8'h55);
    check("bad signature", 16'h0000, irq_hold_o);
    cpu(1'b1, CHANGE_GUARD_OFS, PROTECTED_IO_UNLOCK);
    check("irq_hold_o open", 16'h0001, irq_hold_o);
    cpu(1'b0, CHANGE_GUARD_OFS, 8'h00);
    check("guard io bit", 16'h0001, cpu_rdata_o);
    repeat (3) ev(0, 1'b1);
    ev(4, 1'b1);
    check("fourth insn write", 16'h0001, prot_ok_o);
    check("irq_hold_o closed", 16'h0000, irq_hold_o);
    cpu(1'b1, CHANGE_GUARD_OFS, PROTECTED_IO_UNLOCK);
    repeat (4) ev(0, 1'b1);
    check("expired hold", 16'h0000, irq_hold_o);
    ev(4, 1'b0);
    check("late write", 16'h0000, prot_ok_o);
    for (int k = 1; k <= 3; k++) begin
      cpu(1'b1, CHANGE_GUARD_OFS, PROTECTED_IO_UNLOCK);
      ev(k, 1'b0);
      ev(4, 1'b0);
      check("cancelled write", 16'h0000, prot_ok_o);
    end
  endtask

  task automatic t_guard_spm;
    cpu(1'b1, CHANGE_GUARD_OFS, SELF_PROGRAM_UNLOCK);
    cpu(1'b0, CHANGE_GUARD_OFS, 8'h00);
    check("guard spm bit", 16'h0002, cpu_rdata_o);
    ev(1, 1'b0);  // a data write must not close this window
    check("spm hold", 16'h0001, irq_hold_o);
    ev(5, 1'b0);
    check("spm store", 16'h0001, spm_ok_o);
    for (int k = 2; k <= 3; k++) begin
      cpu(1'b1, CHANGE_GUARD_OFS, SELF_PROGRAM_UNLOCK);
      ev(k, 1'b0);
      ev(5, 1'b0);
      check("cancelled store", 16'h0000, spm_ok_o);
    end
  endtask

  ////////////////////////////////////////
  // main sequence
  initial begin
    repeat (2) @(posedge clock_i);
    rst_n_i <= 1'b1;
    t_reset();
    t_regs();
    t_ptr();
    t_io16();
    t_guard_io();
    t_guard_spm();
    conclude();
  end
endmodule

`default_nettype wire
